/* File: rtl/vih_pkg.sv */
`default_nettype none
package vih_pkg;
  // Source and level geometry
  localparam int N_SRC = 512;
  localparam int IDX_W = 9;
  localparam int N_LVL = 16;
  localparam int LVL_W = 4;
  localparam int RUN_W = 5;
  localparam int VEC_W = IDX_W + 1;
  // Run level shown when nothing is in service
  localparam logic [RUN_W-1:0] LVL_NONE  = 5'h10;
  // Reset values of per-source configuration, in-service levels and read vector
  localparam logic [LVL_W-1:0] PRIO_RST  = 4'hf;
  localparam logic             EN_RST    = 1'b0;
  localparam logic [N_LVL-1:0] ISV_RST   = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_RST   = 10'h000;
  // Position of the valid flag inside a returned vector
  localparam int VEC_VALID_BIT = IDX_W;

  typedef logic [N_LVL-1:0] vih_lvl_vec_t;

  // Lowest set level (highest priority), LVL_NONE when empty
  function automatic logic [RUN_W-1:0] vih_first_level(input vih_lvl_vec_t v);
    logic [RUN_W-1:0] r;
    r = LVL_NONE;
    for (int i = N_LVL - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = RUN_W'(i);
      end
    end
    return r;
  endfunction : vih_first_level
endpackage : vih_pkg
`default_nettype wire

/* File: rtl/vih_sel_if.sv */
`default_nettype none
interface vih_sel_if;
  import vih_pkg::*;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] en;
  logic [LVL_W-1:0] prio [N_SRC];
  logic             best_valid;
  logic [IDX_W-1:0] best_idx;
  logic [LVL_W-1:0] best_prio;

  modport ctrl (output pend, output en, output prio,
                input best_valid, input best_idx, input best_prio);
  modport res  (input pend, input en, input prio,
                output best_valid, output best_idx, output best_prio);
endinterface : vih_sel_if
`default_nettype wire

/* File: rtl/vih_resolver.sv */
`default_nettype none
module vih_resolver
  import vih_pkg::*;
(
  vih_sel_if.res s
);
  logic             v;
  logic [IDX_W-1:0] ix;
  logic [LVL_W-1:0] pr;

  // Scan downward so that equal levels settle on the lowest index
  always_comb
  begin
    v  = 1'b0;
    ix = '0;
    pr = '1;
    for (int i = N_SRC - 1; i >= 0; i--)
    begin
      if (s.pend[i] && s.en[i] && (!v || s.prio[i] <= pr))
      begin
        v  = 1'b1;
        ix = IDX_W'(i);
        pr = s.prio[i];
      end
    end
  end

  // Winner out to the controller
  assign s.best_valid = v;
  assign s.best_idx   = ix;
  assign s.best_prio  = pr;
endmodule : vih_resolver
`default_nettype wire

/* File: rtl/vih_ctrl.sv */
// Notes on behaviour
// - Up to 512 sources, each with its own enable and priority.
// - Level zero is the highest priority and beats every other level.
// - Levels one to fifteen are also assignable to any source.
// - Writing one to a source's raw bit makes it pending.
// - Functional vector read acknowledges the best pending enabled source and returns it.
// - Writing zero to a source's raw bit clears its pending state unless its SRC_IN bit is set in the same cycle.
// - Any vector write ends the current service and frees its level.
// - Handshake works without the core ever taking the interrupt.
// - Higher level preempts lower service, also when the same source refires.
// - Functional vector reads change internal state.
// - Debugger reads return contents without any state change.
`default_nettype none
module vih_ctrl
  import vih_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic [N_SRC-1:0] SRC_IN,
  input  wire logic             CFG_WR,
  input  wire logic [IDX_W-1:0] CFG_IDX,
  input  wire logic             CFG_EN,
  input  wire logic [LVL_W-1:0] CFG_PRIO,
  input  wire logic             RAW_WR,
  input  wire logic [IDX_W-1:0] RAW_IDX,
  input  wire logic             RAW_VAL,
  input  wire logic             VEC_RD,
  input  wire logic             VEC_RD_DBG,
  input  wire logic             VEC_WR,
  output logic      [VEC_W-1:0] VEC_RDATA,
  output logic                  VEC_RVALID,
  output logic                  IRQ,
  output logic      [RUN_W-1:0] RUN_LEVEL,
  output logic      [N_SRC-1:0] PENDING
);
  logic [N_SRC-1:0] pending_reg;
  logic [N_SRC-1:0] pending_next;
  logic [N_SRC-1:0] en_reg;
  logic [LVL_W-1:0] prio_reg [N_SRC];
  vih_lvl_vec_t     isv_reg;
  vih_lvl_vec_t     isv_next;
  logic [VEC_W-1:0] vec_reg;
  logic             rvalid_reg;
  logic             irq_reg;
  logic [RUN_W-1:0] run_reg;
  logic [RUN_W-1:0] run_level;
  vih_lvl_vec_t     eoi_mask;
  logic             func_rd;
  logic             do_ack;
  logic             preempt;
  logic [VEC_W-1:0] vec_now;

  vih_sel_if sel ();

  // Selection of the best pending enabled source
  vih_resolver u_res (
    .s (sel)
  );

  assign sel.pend = pending_reg;
  assign sel.en   = en_reg;
  assign sel.prio = prio_reg;

  // Decode of accesses and current service level
  assign run_level = vih_first_level(isv_reg);
  assign func_rd   = VEC_RD && !VEC_RD_DBG;
  assign do_ack    = func_rd && sel.best_valid;
  assign eoi_mask  = (run_level == LVL_NONE) ? ISV_RST
                   : (vih_lvl_vec_t'(1) << run_level[LVL_W-1:0]);
  assign preempt   = sel.best_valid && ({1'b0, sel.best_prio} < run_level);
  assign vec_now   = sel.best_valid ? {1'b1, sel.best_idx} : VEC_RST;

  // Pending next: ack clears, raw write sets or clears, hardware events win
  always_comb
  begin
    pending_next = pending_reg;
    if (do_ack)
    begin
      pending_next[sel.best_idx] = 1'b0;
    end
    if (RAW_WR)
    begin
      pending_next[RAW_IDX] = RAW_VAL;
    end
    pending_next = pending_next | SRC_IN;
  end

  // In-service levels: end of service first, then the new ack
  always_comb
  begin
    isv_next = isv_reg;
    if (VEC_WR)
    begin
      isv_next = isv_next & ~eoi_mask;
    end
    if (do_ack)
    begin
      isv_next[sel.best_prio] = 1'b1;
    end
  end

  // Per-source configuration store
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      en_reg <= {N_SRC{EN_RST}};
      for (int i = 0; i < N_SRC; i++)
      begin
        prio_reg[i] <= PRIO_RST;
      end
    end
    else if (CFG_WR)
    begin
      en_reg[CFG_IDX]   <= CFG_EN;
      prio_reg[CFG_IDX] <= CFG_PRIO;
    end
  end

  // Handshake state and registered outputs
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pending_reg <= '0;
      isv_reg     <= ISV_RST;
      vec_reg     <= VEC_RST;
      rvalid_reg  <= 1'b0;
      irq_reg     <= 1'b0;
      run_reg     <= LVL_NONE;
    end
    else
    begin
      pending_reg <= pending_next;
      isv_reg     <= isv_next;
      rvalid_reg  <= VEC_RD;
      irq_reg     <= preempt;
      run_reg     <= vih_first_level(isv_next);
      if (VEC_RD)
      begin
        vec_reg <= vec_now;
      end
    end
  end

  assign VEC_RDATA  = vec_reg;
  assign VEC_RVALID = rvalid_reg;
  assign IRQ        = irq_reg;
  assign RUN_LEVEL  = run_reg;
  assign PENDING    = pending_reg;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_raw_set;
    RAW_WR && RAW_VAL |=> pending_reg[$past(RAW_IDX)];
  endproperty
  a_raw_set: assert property (p_raw_set) else $error("raw set lost");

  property p_raw_clr;
    RAW_WR && !RAW_VAL && !SRC_IN[RAW_IDX] |=> !pending_reg[$past(RAW_IDX)];
  endproperty
  a_raw_clr: assert property (p_raw_clr) else $error("raw clear lost");

  property p_ack;
    do_ack |=> VEC_RVALID && VEC_RDATA == {1'b1, $past(sel.best_idx)}
           && isv_reg[$past(sel.best_prio)];
  endproperty
  a_ack: assert property (p_ack) else $error("ack wrong vector or level");

  property p_dbg_quiet;
    VEC_RD && VEC_RD_DBG && !VEC_WR && !RAW_WR && SRC_IN == '0
      |=> $stable(pending_reg) && $stable(isv_reg);
  endproperty
  a_dbg_quiet: assert property (p_dbg_quiet) else $error("debug read changed state");

  property p_func_rd_acts;
    do_ack && !RAW_WR && SRC_IN == '0 |=> !pending_reg[$past(sel.best_idx)];
  endproperty
  a_func_rd_acts: assert property (p_func_rd_acts) else $error("ack kept pending");

  property p_eoi;
    VEC_WR && !func_rd |=> isv_reg == ($past(isv_reg) & ~$past(eoi_mask));
  endproperty
  a_eoi: assert property (p_eoi) else $error("end of service wrong");

  // A raw set of an enabled source better than the running level must raise a request
  property p_preempt;
    RAW_WR && RAW_VAL && !VEC_RD && !VEC_WR && !CFG_WR && en_reg[RAW_IDX]
      && ({1'b0, prio_reg[RAW_IDX]} < run_level) |=> ##1 IRQ;
  endproperty
  a_preempt: assert property (p_preempt) else $error("no preemption request");

  property p_no_irq;
    !preempt |=> !IRQ;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious request");

  // Nothing can outrank a level zero service routine
  property p_lvl0_top;
    run_level == '0 |=> !IRQ;
  endproperty
  a_lvl0_top: assert property (p_lvl0_top) else $error("request above level zero");

  property p_best;
    sel.best_valid |-> pending_reg[sel.best_idx] && en_reg[sel.best_idx];
  endproperty
  a_best: assert property (p_best) else $error("winner not pending");

  property p_cfg;
    CFG_WR |=> prio_reg[$past(CFG_IDX)] == $past(CFG_PRIO);
  endproperty
  a_cfg: assert property (p_cfg) else $error("priority not stored");

  c_ack:    cover property (do_ack);
  c_eoi:    cover property (VEC_WR && isv_reg != ISV_RST);
  c_nested: cover property ($countones(isv_reg) >= 2);
  c_dbg:    cover property (VEC_RD && VEC_RD_DBG && sel.best_valid);
endmodule : vih_ctrl
`default_nettype wire

/* File: tb/vih_core_model.sv */
`default_nettype none
module vih_core_model
#(
  parameter int EOI_DLY = 5
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic on,
  input  wire logic irq,
  output logic      ack_rd,
  output logic      eoi_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  // Core with interrupts masked: acknowledge, wait, end of interrupt
  always @(posedge clk)
  begin
    if (!rst_n || !on)
    begin
      ack_rd  <= 1'b0;
      eoi_wr  <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else if (cnt_reg == 4'h0)
    begin
      ack_rd  <= irq;
      eoi_wr  <= 1'b0;
      cnt_reg <= irq ? 4'h1 : 4'h0;
    end
    else
    begin
      ack_rd  <= 1'b0;
      eoi_wr  <= (cnt_reg == 4'(EOI_DLY));
      cnt_reg <= (cnt_reg == 4'(EOI_DLY)) ? 4'h0 : cnt_reg + 4'h1;
    end
  end
endmodule : vih_core_model
`default_nettype wire

/* File: tb/test_vectored_irq_handshake.sv */
`default_nettype none
module test_vectored_irq_handshake
  import vih_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int K_CFG = 0, K_RAW = 1, K_RD = 2, K_DBG = 3, K_EOI = 4;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [N_SRC-1:0] src = '0;
  logic             cfg_wr = 1'b0, raw_wr = 1'b0, vec_rd = 1'b0, dbg = 1'b0, vec_wr = 1'b0;
  logic [IDX_W-1:0] idx = '0;
  logic             val = 1'b0;
  logic [LVL_W-1:0] prio = '0;
  logic             core_on = 1'b0;
  wire logic        core_rd, core_eoi, vec_rvalid, irq;
  wire logic [VEC_W-1:0] vec_rdata;
  wire logic [RUN_W-1:0] run_level;
  wire logic [N_SRC-1:0] pending;
  logic [VEC_W-1:0] exp_q [$];
  int               bad_count = 0, n_checks = 0, seed = 2766, a;
  logic [LVL_W-1:0] lv;

  always #2.5 clk = ~clk;

  vih_ctrl vih_ctrl_inst (.CLK(clk), .RST_N(rst_n), .SRC_IN(src), .CFG_WR(cfg_wr),
    .CFG_IDX(idx), .CFG_EN(val), .CFG_PRIO(prio), .RAW_WR(raw_wr), .RAW_IDX(idx),
    .RAW_VAL(val), .VEC_RD(vec_rd | core_rd), .VEC_RD_DBG(dbg), .VEC_WR(vec_wr | core_eoi),
    .VEC_RDATA(vec_rdata), .VEC_RVALID(vec_rvalid), .IRQ(irq), .RUN_LEVEL(run_level),
    .PENDING(pending));
  vih_core_model vih_core_model_inst (.clk(clk), .rst_n(rst_n), .on(core_on), .irq(irq),
    .ack_rd(core_rd), .eoi_wr(core_eoi));

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input logic [N_SRC-1:0] seen, input logic [N_SRC-1:0] want);
    n_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // One strobe of the chosen kind, held for one taking edge
  task automatic req(input int k, input int i, input logic v, input logic [LVL_W-1:0] p);
    @(posedge clk);
    cfg_wr <= (k == K_CFG);
    raw_wr <= (k == K_RAW);
    vec_rd <= (k == K_RD || k == K_DBG);
    dbg    <= (k == K_DBG);
    vec_wr <= (k == K_EOI);
    idx    <= IDX_W'(i);
    val    <= v;
    prio   <= p;
    @(posedge clk);
    {cfg_wr, raw_wr, vec_rd, dbg, vec_wr} <= '0;
  endtask : req

  task automatic rd(input int k, input logic [VEC_W-1:0] e);
    exp_q.push_back(e);
    req(k, 0, 1'b0, 4'h0);
  endtask : rd

  // Each read answer is matched against the oldest noted vector
  always @(posedge clk)
  begin
    if (vec_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        exp_q.push_back('x);
      chk(N_SRC'(vec_rdata), N_SRC'(exp_q.pop_front()));
    end
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wt(1);
    chk(run_level, LVL_NONE);
    chk({irq, vec_rvalid}, 2'h0);
    chk(pending, '0);
    req(K_CFG, 5, 1'b1, 4'h3);
    req(K_RAW, 5, 1'b1, 4'h0);
    wt(1);
    chk({irq, pending[5]}, 2'h3);
    rd(K_DBG, 10'h205);
    wt(1);
    chk({run_level, pending[5]}, {LVL_NONE, 1'b1});
    rd(K_RD, 10'h205);
    wt(1);
    chk({run_level, pending[5]}, {5'h03, 1'b0});
    req(K_CFG, 9, 1'b1, 4'h0);
    for (int r = 0; r < 2; r++)
    begin
      req(K_RAW, 9, 1'b1, 4'h0);
      wt(1);
      chk(irq, 1'b1);
      rd(K_RD, 10'h209);
      wt(1);
      chk(run_level, 5'h00);
      req(K_EOI, 0, 1'b0, 4'h0);
      wt(1);
      chk(run_level, 5'h03);
    end
    rd(K_RD, 10'h000);
    req(K_EOI, 0, 1'b0, 4'h0);
    wt(1);
    chk(run_level, LVL_NONE);
    req(K_RAW, 7, 1'b1, 4'h0);
    req(K_RAW, 7, 1'b0, 4'h0);
    req(K_CFG, 300, 1'b1, 4'h1);
    req(K_CFG, 300, 1'b0, 4'h1);
    @(posedge clk);
    src[300] <= 1'b1;
    @(posedge clk);
    src[300] <= 1'b0;
    wt(1);
    chk(pending[300], 1'b1);
    chk(irq, 1'b0);
    rd(K_RD, 10'h000);
    req(K_RAW, 300, 1'b0, 4'h0);
    wt(1);
    chk(pending, '0);
    req(K_CFG, 511, 1'b1, 4'hf);
    req(K_RAW, 511, 1'b1, 4'h0);
    rd(K_RD, 10'h3ff);
    req(K_EOI, 0, 1'b0, 4'h0);
    for (int k = 0; k < 4; k++)
    begin
      a = 40 + 50 * k + int'($unsigned($random(seed)) % 40);
      lv = LVL_W'(1 + $unsigned($random(seed)) % 15);
      req(K_CFG, a + 3, 1'b1, lv);
      req(K_CFG, a, 1'b1, lv);
      req(K_RAW, a + 3, 1'b1, 4'h0);
      req(K_RAW, a, 1'b1, 4'h0);
      rd(K_RD, {1'b1, IDX_W'(a)});
      rd(K_RD, {1'b1, IDX_W'(a + 3)});
      wt(1);
      chk(run_level, {1'b0, lv});
      req(K_EOI, 0, 1'b0, 4'h0);
      wt(1);
      chk(run_level, LVL_NONE);
    end
    req(K_CFG, 20, 1'b1, 4'h2);
    exp_q.push_back(10'h214);
    core_on <= 1'b1;
    req(K_RAW, 20, 1'b1, 4'h0);
    wt(12);
    chk({run_level, pending[20]}, {LVL_NONE, 1'b0});
    chk(N_SRC'(exp_q.size()), '0);
    summarize();
  end
endmodule : test_vectored_irq_handshake
`default_nettype wire
